// ===== pkg/line_ctrl_pkg.sv
// Purpose: Shared types and constants for the data cache line state controller.
// Assumes: Four ways per set and four longwords per line.
// Notes:   Register offsets are byte addresses on a 32-bit AHB-Lite slave.
package line_ctrl_pkg;
  localparam int WAYS        = 4;
  localparam int LW_PER_LINE = 4;

  typedef enum logic [1:0] {
    LS_INV   = 2'h0,
    LS_VAL   = 2'h1,
    LS_DIRTY = 2'h3
  } line_state_t;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_INV   = 2'h2,
    OP_PUSH  = 2'h3
  } cpu_op_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_FILL  = 4'h2,
    ST_WB    = 4'h4,
    ST_MEMWR = 4'h8
  } seq_state_t;

  localparam logic [1:0]  SC_LEAVE_DIRTY = 2'h1;
  localparam logic [1:0]  SC_INVALIDATE  = 2'h2;

  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_SNOOP_CNT = 8'h08;
  localparam int          CTRL_SNOOP_EN  = 0;
  localparam logic        CTRL_RESET     = 1'h1;
  localparam int          STAT_SEQ_LSB   = 0;
  localparam int          STAT_BUF_BIT   = 8;
  localparam int          STAT_INH_BIT   = 9;
  localparam logic        HRESP_OKAY     = 1'h0;
endpackage : line_ctrl_pkg

// ===== pkg/snoop_decide_if.sv
// Purpose: Carries one snoop lookup to the snoop decider and its verdict back.
// Assumes: The decider is purely combinational.
// Notes:   cur is the state of the line or of the copyback buffer.
`timescale 1ns/1ps
`default_nettype none
interface snoop_decide_if;
  import line_ctrl_pkg::*;
  logic        is_read;
  logic [1:0]  code;
  logic        full_line;
  logic        hit_line;
  line_state_t cur;
  logic [3:0]  lw_mask;
  line_state_t nxt;
  logic [3:0]  set_marks;
  logic        inhibit;
  logic        source;
  logic        sink;
  modport decider (input is_read, code, full_line, hit_line, cur, lw_mask,
                   output nxt, set_marks, inhibit, source, sink);
  modport user (output is_read, code, full_line, hit_line, cur, lw_mask,
                input nxt, set_marks, inhibit, source, sink);
endinterface : snoop_decide_if
`default_nettype wire

// ===== logic/snoop_decider.sv
// Purpose: Decides the snoop action for one line or the copyback buffer.
// Assumes: Codes 00 and 11 request no snooping.
// Notes:   Clock and reset serve the assertions only.
`timescale 1ns/1ps
`default_nettype none
module snoop_decider
  import line_ctrl_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  snoop_decide_if.decider  dec
);
  always_comb begin
    dec.nxt       = dec.cur;
    dec.set_marks = 4'h0;
    dec.inhibit   = 1'b0;
    dec.source    = 1'b0;
    dec.sink      = 1'b0;
    if (dec.hit_line && dec.cur != LS_INV) begin
      case (dec.code)
        SC_LEAVE_DIRTY: begin
          if (dec.is_read) begin
            dec.inhibit = (dec.cur == LS_DIRTY);
            dec.source  = (dec.cur == LS_DIRTY);
          end else if (dec.cur == LS_DIRTY && !dec.full_line) begin
            dec.inhibit   = 1'b1;
            dec.sink      = 1'b1;
            dec.set_marks = dec.lw_mask;
          end else begin
            dec.nxt = LS_INV;
          end
        end
        SC_INVALIDATE: begin
          dec.nxt = LS_INV;
          if (dec.is_read) begin
            dec.inhibit = (dec.cur == LS_DIRTY);
            dec.source  = (dec.cur == LS_DIRTY);
          end
        end
        default: begin
          dec.nxt = dec.cur;
        end
      endcase
    end
  end

  a_snoop_write_inval: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (dec.hit_line && dec.cur != LS_INV && !dec.is_read && dec.code == SC_INVALIDATE)
    |-> (dec.nxt == LS_INV && !dec.inhibit && !dec.sink))
    else $error("Snooped invalidating write did not simply invalidate.");

  a_snoop_sink_dirty: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (dec.hit_line && dec.cur == LS_DIRTY && !dec.is_read && dec.code == SC_LEAVE_DIRTY
     && !dec.full_line) |-> (dec.inhibit && dec.sink && dec.nxt == LS_DIRTY))
    else $error("Partial leave-dirty write on dirty line not sunk.");
endmodule : snoop_decider
`default_nettype wire

// ===== logic/dcache_line_ctrl.sv
// Purpose: Line state controller of a four-way data cache with snooping.
// Assumes: Tag lookup, hit and victim way come from outside on this clock.
// Notes:   Snoop pins are asynchronous and pass two flip-flops first.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Read miss on invalid or clean victim fills line, supplies core, leaves it valid.
// - Read miss on dirty victim buffers it, fills, supplies, then writes buffer back.
// - Read hit supplies core with no memory access and no state change.
// - Copyback write miss fills line, merges write, sets longword marks, goes dirty.
// - Copyback write miss on dirty victim also writes the buffered victim back.
// - Write-through write miss writes memory only, no allocation, no state change.
// - Copyback write hit on valid line sets written marks and goes dirty.
// - Copyback write hit on dirty line sets written marks and stays dirty.
// - Write-through write hit on valid line writes cache and memory, stays valid.
// - Write-through hit on dirty line keeps marks unchanged and stays dirty.
// - Invalidate drops valid and dirty lines with no memory write.
// - Push buffers and invalidates a dirty line, then writes the buffer back; valid lines just invalidate.
// - Leave-dirty snooped read hitting dirty line inhibits memory and sources data.
// - Invalidating snooped read invalidates; dirty line first inhibits and sources.
// - Invalidating snooped write invalidates without inhibit or data transfer.
// - Partial leave-dirty write on dirty line is sunk; other write hits invalidate.
// - Memory inhibit stays asserted during a serviced snooped access.
// - Snoops also check the copyback buffer holding an evicted dirty line.
module dcache_line_ctrl
  import line_ctrl_pkg::*;
#(
  parameter int NSETS = 16,
  parameter int TAG_W = 20,
  parameter int SET_W = $clog2(NSETS)
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_hsel,
  input  wire logic [31:0]      i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic [31:0]      i_hwdata,
  input  wire logic             i_hready,
  output logic      [31:0]      o_hrdata,
  output logic                  o_hreadyout,
  output logic                  o_hresp,
  input  wire logic             i_req_valid,
  input  wire logic [1:0]       i_req_op,
  input  wire logic             i_req_copyback,
  input  wire logic             i_req_hit,
  input  wire logic [SET_W-1:0] i_req_set,
  input  wire logic [1:0]       i_req_way,
  input  wire logic [TAG_W-1:0] i_req_victim_tag,
  input  wire logic [3:0]       i_req_lw_mask,
  output logic                  o_req_ready,
  output logic                  o_req_done,
  output logic                  o_core_supply,
  output logic                  o_fill_req,
  input  wire logic             i_fill_done,
  output logic                  o_wb_req,
  input  wire logic             i_wb_done,
  output logic                  o_mem_write_req,
  input  wire logic             i_mem_write_done,
  input  wire logic             i_snp_valid,
  input  wire logic             i_snp_read,
  input  wire logic [1:0]       i_snoop_action_code,
  input  wire logic             i_snp_full_line,
  input  wire logic             i_snp_hit,
  input  wire logic [SET_W-1:0] i_snp_set,
  input  wire logic [1:0]       i_snp_way,
  input  wire logic [TAG_W-1:0] i_snp_tag,
  input  wire logic [3:0]       i_snp_lw_mask,
  output logic                  o_snoop_memory_inhibit,
  output logic                  o_snoop_source,
  output logic                  o_snoop_sink,
  output logic                  o_snoop_from_buffer
);
  localparam int LINES = NSETS * WAYS;
  localparam int IDX_W = SET_W + 2;
  localparam int SN_W  = 12 + SET_W + TAG_W;

  line_state_t      state_r [LINES];
  line_state_t      state_nxt [LINES];
  logic [3:0]       longword_dirty_marks_r [LINES];
  logic [3:0]       longword_dirty_marks_nxt [LINES];
  seq_state_t       seq_r, seq_nxt;
  logic             buf_valid_r, buf_valid_nxt;
  logic [SET_W-1:0] buf_set_r, buf_set_nxt;
  logic [TAG_W-1:0] buf_tag_r, buf_tag_nxt;
  logic [3:0]       buf_marks_r, buf_marks_nxt;
  logic [IDX_W-1:0] p_idx_r, p_idx_nxt;
  cpu_op_t          p_op_r, p_op_nxt;
  logic [3:0]       p_mask_r, p_mask_nxt;
  logic             done_nxt, supply_nxt, fill_nxt, wb_nxt, mw_nxt, ready_nxt;
  logic [SN_W-1:0]  sn1_r, sn2_r;
  logic             sv_d_r;
  logic             inh_nxt, src_nxt, snk_nxt, frb_nxt;
  logic             snoop_en_r, snoop_en_nxt;
  logic [31:0]      snoop_cnt_r, snoop_cnt_nxt;
  logic             wr_pend_r, wr_pend_nxt;
  logic [7:0]       wr_addr_r, wr_addr_nxt;
  logic [31:0]      rdata_nxt;
  logic             s_valid, s_read, s_full, s_hit, snp_evt, buf_match, req_take;
  logic [1:0]       s_code, s_way;
  logic [SET_W-1:0] s_set;
  logic [TAG_W-1:0] s_tag;
  logic [3:0]       s_mask;
  logic [IDX_W-1:0] r_idx, s_idx;
  logic             ahb_take;

  snoop_decide_if dec ();
  snoop_decider u_decider (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .dec     (dec.decider)
  );

  // The alternate master must hold all snoop fields steady before raising valid,
  // since the two stages may otherwise pair a new valid with stale fields.
  assign {s_valid, s_read, s_code, s_full, s_hit, s_set, s_way, s_tag, s_mask} = sn2_r;
  assign snp_evt   = s_valid && !sv_d_r && snoop_en_r;
  assign buf_match = buf_valid_r && s_set == buf_set_r && s_tag == buf_tag_r;
  assign r_idx     = {i_req_set, i_req_way};
  assign s_idx     = {s_set, s_way};
  assign req_take  = i_req_valid && o_req_ready;
  assign ahb_take  = i_hsel && i_hready && i_htrans[1];

  assign dec.is_read   = s_read;
  assign dec.code      = s_code;
  assign dec.full_line = s_full;
  assign dec.hit_line  = buf_match || s_hit;
  assign dec.cur       = buf_match ? LS_DIRTY : state_r[s_idx];
  assign dec.lw_mask   = s_mask;

  always_comb begin
    seq_nxt = seq_r;
    state_nxt = state_r;
    longword_dirty_marks_nxt = longword_dirty_marks_r;
    buf_valid_nxt = buf_valid_r;
    buf_set_nxt = buf_set_r;
    buf_tag_nxt = buf_tag_r;
    buf_marks_nxt = buf_marks_r;
    p_idx_nxt = p_idx_r;
    p_op_nxt = p_op_r;
    p_mask_nxt = p_mask_r;
    done_nxt = 1'b0;
    supply_nxt = 1'b0;
    fill_nxt = o_fill_req;
    wb_nxt = o_wb_req;
    mw_nxt = o_mem_write_req;
    case (seq_r)
      ST_IDLE: begin
        if (i_req_valid) begin
          p_idx_nxt = r_idx;
          p_op_nxt = cpu_op_t'(i_req_op);
          p_mask_nxt = i_req_lw_mask;
          if ((i_req_op == OP_READ || i_req_op == OP_WRITE && i_req_copyback) && !i_req_hit
              || i_req_op == OP_PUSH) begin
            if (state_r[r_idx] == LS_DIRTY) begin
              buf_valid_nxt = 1'b1;
              buf_set_nxt = i_req_set;
              buf_tag_nxt = i_req_victim_tag;
              buf_marks_nxt = longword_dirty_marks_r[r_idx];
            end
            state_nxt[r_idx] = LS_INV;
            longword_dirty_marks_nxt[r_idx] = 4'h0;
          end
          case (cpu_op_t'(i_req_op))
            OP_READ: begin
              if (i_req_hit) begin
                supply_nxt = 1'b1;
                done_nxt = 1'b1;
              end else begin
                fill_nxt = 1'b1;
                seq_nxt = ST_FILL;
              end
            end
            OP_WRITE: begin
              if (!i_req_copyback) begin
                mw_nxt = 1'b1;
                seq_nxt = ST_MEMWR;
              end else if (i_req_hit) begin
                state_nxt[r_idx] = LS_DIRTY;
                longword_dirty_marks_nxt[r_idx] =
                  longword_dirty_marks_r[r_idx] | i_req_lw_mask;
                done_nxt = 1'b1;
              end else begin
                fill_nxt = 1'b1;
                seq_nxt = ST_FILL;
              end
            end
            OP_INV: begin
              state_nxt[r_idx] = LS_INV;
              longword_dirty_marks_nxt[r_idx] = 4'h0;
              done_nxt = 1'b1;
            end
            default: begin
              if (state_r[r_idx] == LS_DIRTY) begin
                wb_nxt = 1'b1;
                seq_nxt = ST_WB;
              end else begin
                done_nxt = 1'b1;
              end
            end
          endcase
        end
      end
      ST_FILL: begin
        if (i_fill_done) begin
          fill_nxt = 1'b0;
          if (p_op_r == OP_READ) begin
            state_nxt[p_idx_r] = LS_VAL;
            supply_nxt = 1'b1;
          end else begin
            state_nxt[p_idx_r] = LS_DIRTY;
            longword_dirty_marks_nxt[p_idx_r] = p_mask_r;
          end
          if (buf_valid_r) begin
            wb_nxt = 1'b1;
            seq_nxt = ST_WB;
          end else begin
            done_nxt = 1'b1;
            seq_nxt = ST_IDLE;
          end
        end
      end
      ST_WB: begin
        if (i_wb_done) begin
          wb_nxt = 1'b0;
          buf_valid_nxt = 1'b0;
          done_nxt = 1'b1;
          seq_nxt = ST_IDLE;
        end
      end
      ST_MEMWR: begin
        if (i_mem_write_done) begin
          mw_nxt = 1'b0;
          done_nxt = 1'b1;
          seq_nxt = ST_IDLE;
        end
      end
      default: begin
        seq_nxt = ST_IDLE;
      end
    endcase
    ready_nxt = (seq_nxt == ST_IDLE);
    // A snoop is applied last so it wins over a processor update of the same line.
    inh_nxt = o_snoop_memory_inhibit && s_valid;
    src_nxt = o_snoop_source && s_valid;
    snk_nxt = o_snoop_sink && s_valid;
    frb_nxt = o_snoop_from_buffer && s_valid;
    snoop_cnt_nxt = snoop_cnt_r;
    if (snp_evt) begin
      inh_nxt = dec.inhibit;
      src_nxt = dec.source;
      snk_nxt = dec.sink;
      frb_nxt = buf_match && dec.inhibit;
      if (dec.inhibit) begin
        snoop_cnt_nxt = snoop_cnt_r + 32'h1;
      end
      if (buf_match) begin
        buf_marks_nxt = buf_marks_r | dec.set_marks;
        buf_valid_nxt = buf_valid_r && dec.nxt != LS_INV;
      end else if (s_hit) begin
        state_nxt[s_idx] = dec.nxt;
        longword_dirty_marks_nxt[s_idx] = (dec.nxt == LS_INV) ? 4'h0 :
          (longword_dirty_marks_r[s_idx] | dec.set_marks);
      end
    end
  end

  always_comb begin
    wr_pend_nxt = ahb_take && i_hwrite;
    wr_addr_nxt = i_haddr[7:0];
    snoop_en_nxt = snoop_en_r;
    if (wr_pend_r && wr_addr_r == ADDR_CTRL) begin
      snoop_en_nxt = i_hwdata[CTRL_SNOOP_EN];
    end
    rdata_nxt = 32'h0;
    if (ahb_take && !i_hwrite) begin
      case (i_haddr[7:0])
        ADDR_CTRL: rdata_nxt[CTRL_SNOOP_EN] = snoop_en_r;
        ADDR_STATUS: begin
          rdata_nxt[STAT_SEQ_LSB +: 4] = seq_r;
          rdata_nxt[STAT_BUF_BIT] = buf_valid_r;
          rdata_nxt[STAT_INH_BIT] = o_snoop_memory_inhibit;
        end
        ADDR_SNOOP_CNT: rdata_nxt = snoop_cnt_r;
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < LINES; i++) begin
        state_r[i] <= LS_INV;
        longword_dirty_marks_r[i] <= 4'h0;
      end
      seq_r <= ST_IDLE;
      buf_valid_r <= 1'b0;
      buf_set_r <= '0;
      buf_tag_r <= '0;
      buf_marks_r <= 4'h0;
      p_idx_r <= '0;
      p_op_r <= OP_READ;
      p_mask_r <= 4'h0;
      o_req_ready <= 1'b1;
      o_req_done <= 1'b0;
      o_core_supply <= 1'b0;
      o_fill_req <= 1'b0;
      o_wb_req <= 1'b0;
      o_mem_write_req <= 1'b0;
      sn1_r <= '0;
      sn2_r <= '0;
      sv_d_r <= 1'b0;
      o_snoop_memory_inhibit <= 1'b0;
      o_snoop_source <= 1'b0;
      o_snoop_sink <= 1'b0;
      o_snoop_from_buffer <= 1'b0;
      snoop_en_r <= CTRL_RESET;
      snoop_cnt_r <= 32'h0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
      o_hrdata <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp <= HRESP_OKAY;
    end else begin
      state_r <= state_nxt;
      longword_dirty_marks_r <= longword_dirty_marks_nxt;
      seq_r <= seq_nxt;
      buf_valid_r <= buf_valid_nxt;
      buf_set_r <= buf_set_nxt;
      buf_tag_r <= buf_tag_nxt;
      buf_marks_r <= buf_marks_nxt;
      p_idx_r <= p_idx_nxt;
      p_op_r <= p_op_nxt;
      p_mask_r <= p_mask_nxt;
      o_req_ready <= ready_nxt;
      o_req_done <= done_nxt;
      o_core_supply <= supply_nxt;
      o_fill_req <= fill_nxt;
      o_wb_req <= wb_nxt;
      o_mem_write_req <= mw_nxt;
      sn1_r <= {i_snp_valid, i_snp_read, i_snoop_action_code, i_snp_full_line, i_snp_hit,
                i_snp_set, i_snp_way, i_snp_tag, i_snp_lw_mask};
      sn2_r <= sn1_r;
      sv_d_r <= s_valid;
      o_snoop_memory_inhibit <= inh_nxt;
      o_snoop_source <= src_nxt;
      o_snoop_sink <= snk_nxt;
      o_snoop_from_buffer <= frb_nxt;
      snoop_en_r <= snoop_en_nxt;
      snoop_cnt_r <= snoop_cnt_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      o_hrdata <= rdata_nxt;
      o_hreadyout <= 1'b1;
      o_hresp <= HRESP_OKAY;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_read_miss;
    req_take && i_req_op == OP_READ && !i_req_hit && !snp_evt;
  endsequence
  sequence s_fill_ends_with_buffer;
    seq_r == ST_FILL && i_fill_done && buf_valid_r && !snp_evt;
  endsequence

  a_read_hit_quiet: assert property (req_take && i_req_op == OP_READ && i_req_hit
    |=> o_req_done && o_core_supply && !o_fill_req && o_req_ready)
    else $error("Read hit did not complete quietly.");
  a_read_miss_fill: assert property (s_read_miss |=> o_fill_req && !o_req_ready)
    else $error("Read miss did not request a fill.");
  a_dirty_victim_buf: assert property (s_read_miss ##0 state_r[r_idx] == LS_DIRTY
    |=> buf_valid_r && state_r[p_idx_r] == LS_INV)
    else $error("Dirty victim not buffered.");
  a_fill_then_wb: assert property (s_fill_ends_with_buffer
    |=> o_wb_req && !o_fill_req && !o_req_done)
    else $error("Buffered victim not written after fill.");
  a_wt_no_alloc: assert property (req_take && i_req_op == OP_WRITE && !i_req_copyback
    |=> o_mem_write_req && !o_fill_req ##1 !o_fill_req)
    else $error("Write-through write allocated a line.");
  a_cb_hit_dirty: assert property (req_take && i_req_op == OP_WRITE && i_req_copyback
    && i_req_hit && !snp_evt |=> state_r[p_idx_r] == LS_DIRTY
    && (longword_dirty_marks_r[p_idx_r] & p_mask_r) == p_mask_r)
    else $error("Copyback write hit did not mark dirty.");
  a_inv_clears: assert property (req_take && i_req_op == OP_INV && !snp_evt
    |=> state_r[p_idx_r] == LS_INV && !o_wb_req && o_req_done)
    else $error("Invalidate left a line or wrote memory.");
  a_inhibit_held: assert property (snp_evt && dec.inhibit
    |=> o_snoop_memory_inhibit [*2] or (o_snoop_memory_inhibit ##1 !s_valid))
    else $error("Memory inhibit not held during serviced snoop.");
  a_buffer_snooped: assert property (snp_evt && buf_match && s_read
    && s_code == SC_INVALIDATE && seq_r != ST_WB |=> !buf_valid_r && o_snoop_from_buffer)
    else $error("Snoop missed the copyback buffer.");
endmodule : dcache_line_ctrl
`default_nettype wire

// ===== bench/mem_responder.sv
// Purpose: Memory side model that answers fill, writeback and write-through requests.
// Assumes: A request stays high until the cycle after its done pulse.
// Notes:   i_wait sets the answer delay so that prompt and slow memory both occur.
`timescale 1ns/1ps
`default_nettype none
module mem_responder (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_req,
  input  wire logic [3:0] i_wait,
  output logic            o_done
);
  logic [3:0] cnt_r;
  logic       ans_r;
  // The answered flag stops a second pulse should the request stay high until the count wraps back to i_wait.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_req) begin
      cnt_r  <= 4'h0;
      ans_r  <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= !ans_r && cnt_r == i_wait;
      ans_r  <= ans_r || cnt_r == i_wait;
      cnt_r  <= cnt_r + 4'h1;
    end
  end
endmodule : mem_responder
`default_nettype wire

// ===== bench/tb_data_cache_line_state_ctrl.sv
// Purpose: Random self-checking bench for the data cache line state controller.
// Assumes: Requests and snoops are issued one at a time while the controller is idle.
// Notes:   Integer line states predict memory traffic and snoop replies.
`timescale 1ns/1ps
`default_nettype none
module tb_data_cache_line_state_ctrl import line_ctrl_pkg::*;;
  logic        i_clk, i_rst_n, i_hsel, i_hwrite, o_hreadyout, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [2:0]  i_hsize, pv;
  logic [1:0]  i_htrans, i_req_op, i_req_way, i_snoop_action_code, i_snp_way;
  logic [3:0]  i_req_set, i_req_lw_mask, i_snp_set, i_snp_lw_mask, lat;
  logic [19:0] i_req_victim_tag, i_snp_tag;
  logic        i_req_valid, i_req_copyback, i_req_hit, o_req_ready, o_req_done;
  logic        o_core_supply, o_fill_req, i_fill_done, o_wb_req, i_wb_done;
  logic        o_mem_write_req, i_mem_write_done, i_snp_valid, i_snp_read;
  logic        i_snp_full_line, i_snp_hit, o_snoop_memory_inhibit, o_snoop_source;
  logic        o_snoop_sink, o_snoop_from_buffer;
  int          err_total, total_checks, st[8], cn[4], sc, en;
  logic [7:0]  ra[4] = '{ADDR_CTRL, ADDR_STATUS, ADDR_SNOOP_CNT, 8'h0c};
  logic [31:0] rv[4] = '{32'h1, 32'h1, 32'h0, 32'h0};
  wire  [2:0]  hs = {o_req_done, o_req_ready, o_hreadyout};
  wire  [2:0]  rq3 = {o_mem_write_req, o_wb_req, o_fill_req};
  dcache_line_ctrl dut (
    .i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
    .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_req_valid, .i_req_op,
    .i_req_copyback, .i_req_hit, .i_req_set, .i_req_way, .i_req_victim_tag, .i_req_lw_mask,
    .o_req_ready, .o_req_done, .o_core_supply, .o_fill_req, .i_fill_done, .o_wb_req,
    .i_wb_done, .o_mem_write_req, .i_mem_write_done, .i_snp_valid, .i_snp_read,
    .i_snoop_action_code, .i_snp_full_line, .i_snp_hit, .i_snp_set, .i_snp_way, .i_snp_tag,
    .i_snp_lw_mask, .o_snoop_memory_inhibit, .o_snoop_source, .o_snoop_sink,
    .o_snoop_from_buffer
  );
  mem_responder fill_mem (.i_clk, .i_rst_n, .i_req(o_fill_req), .i_wait(lat),
                          .o_done(i_fill_done));
  mem_responder wb_mem (.i_clk, .i_rst_n, .i_req(o_wb_req), .i_wait(lat), .o_done(i_wb_done));
  mem_responder wr_mem (.i_clk, .i_rst_n, .i_req(o_mem_write_req), .i_wait(lat),
                        .o_done(i_mem_write_done));
  always #20 i_clk = !i_clk;
  // Counting at the falling edge keeps the tally clear of the updates at the rising edge.
  always @(negedge i_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rq3[i] === 1'b1 && pv[i] !== 1'b1) cn[i]++;
    end
    if (o_core_supply === 1'b1) cn[3]++;
    pv = rq3;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (hs[k] !== 1'b1 && n < 300);
    if (n >= 300) begin
      chk("wait bound", 0, 1);
      test_done;
    end
  endtask : wait_hi
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    i_hsel   <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr  <= {24'h0, a};
    i_hwrite <= wr;
    i_hsize  <= 3'h2;
    wait_hi(0);
    @(posedge i_clk);
    i_hsel   <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_hi(0);
    rd = o_hrdata;
    chk("bus response", 32'(HRESP_OKAY), 32'(o_hresp));
    @(posedge i_clk);
  endtask : ahb
  task automatic rq(input int op, input int cb, input int ln);
    int s, h, e, ns, a[4];
    s  = st[ln];
    h  = s != 0 ? $urandom % 2 : 0;
    e  = 0;
    ns = s;
    if (op == 0) begin
      e  = h ? 16'h1 : (s == 3 ? 16'h1101 : 16'h1001);
      ns = h ? s : 1;
    end else if (op == 1 && cb == 1) begin
      e  = h ? 16'h0 : (s == 3 ? 16'h1100 : 16'h1000);
      ns = 3;
    end else if (op == 1) begin
      e = 16'h10;
    end else begin
      e  = (op == 3 && s == 3) ? 16'h100 : 16'h0;
      ns = 0;
    end
    a = cn;
    lat              <= 4'($urandom % 4);
    i_req_valid      <= 1'b1;
    i_req_op         <= op[1:0];
    i_req_copyback   <= cb[0];
    i_req_hit        <= h[0];
    i_req_set        <= {3'h0, ln[2]};
    i_req_way        <= ln[1:0];
    i_req_victim_tag <= 20'($urandom);
    i_req_lw_mask    <= 4'($urandom % 15 + 1);
    wait_hi(1);
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    wait_hi(2);
    @(posedge i_clk);
    e = e - ((cn[0] - a[0]) << 12) - ((cn[1] - a[1]) << 8) - ((cn[2] - a[2]) << 4);
    chk("memory traffic", 0, e - cn[3] + a[3]);
    st[ln] = ns;
  endtask : rq
  task automatic sn(input int rd_n, input int code, input int full, input int ln);
    int s, ns, e;
    s  = st[ln];
    ns = s;
    e  = 0;
    if (en == 1 && s != 0) begin
      if (rd_n == 1 && (code == 1 || code == 2)) e = s == 3 ? 16'h110 : 16'h0;
      if (code == 2 || (code == 1 && rd_n == 0 && (s == 1 || full == 1))) ns = 0;
      if (code == 1 && rd_n == 0 && s == 3 && full == 0) e = 16'h101;
    end
    sc += e >= 16'h100;
    i_snp_read          <= rd_n[0];
    i_snoop_action_code <= code[1:0];
    i_snp_full_line     <= full[0];
    i_snp_hit           <= s != 0;
    i_snp_set           <= {3'h0, ln[2]};
    i_snp_way           <= ln[1:0];
    i_snp_tag           <= 20'($urandom);
    i_snp_lw_mask       <= 4'($urandom % 15 + 1);
    repeat (3) @(posedge i_clk);
    i_snp_valid <= 1'b1;
    repeat (6) @(negedge i_clk);
    chk("snoop reply", e, {o_snoop_from_buffer, 3'h0, o_snoop_memory_inhibit, 3'h0,
        o_snoop_source, 3'h0, o_snoop_sink});
    @(posedge i_clk);
    i_snp_valid <= 1'b0;
    i_snp_hit   <= s == 0;
    repeat (6) @(negedge i_clk);
    chk("snoop release", 0, {o_snoop_memory_inhibit, o_snoop_source, o_snoop_sink});
    @(posedge i_clk);
    st[ln] = ns;
  endtask : sn
  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    {i_hsel, i_haddr, i_htrans, i_hwrite, i_hsize, i_hwdata, i_req_valid, i_req_op} = '0;
    {i_req_copyback, i_req_hit, i_req_set, i_req_way, i_req_victim_tag, i_req_lw_mask} = '0;
    {i_snp_valid, i_snp_read, i_snoop_action_code, i_snp_full_line, i_snp_hit} = '0;
    {i_snp_set, i_snp_way, i_snp_tag, i_snp_lw_mask, lat} = '0;
    void'($urandom(33126));
    en = 1;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    ahb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, ra[i], 32'h0);
      chk("register reset", rv[i], rd);
    end
    $display("test registers done");
    // Snooping is switched off for a stretch so that the enable bit is seen to matter.
    for (int it = 0; it < 240; it++) begin
      if (it == 120 || it == 160) begin
        en = it == 160;
        ahb(1'b1, ADDR_CTRL, 32'(en));
      end
      if ($urandom % 3 == 0) sn($urandom % 2, $urandom % 4, $urandom % 2, $urandom % 8);
      else rq($urandom % 4, $urandom % 2, $urandom % 8);
    end
    $display("test random traffic done");
    ahb(1'b0, ADDR_SNOOP_CNT, 32'h0);
    chk("inhibit count", 32'(sc), rd);
    $display("test snoop count done");
    test_done;
  end
endmodule : tb_data_cache_line_state_ctrl
`default_nettype wire
